// file: core/readout_ctrl_consts.svh
`ifndef READOUT_CTRL_CONSTS_SVH
`define READOUT_CTRL_CONSTS_SVH

// register offsets
`define OFS_BASE_HI 16'h1012
`define OFS_BASE_LO 16'h1014
`define OFS_ONE_SHOT_RST 16'h1016
`define OFS_CHAIN_CTRL 16'h101A
`define OFS_EVT_THRESHOLD 16'h1020
`define OFS_STATUS 16'h1022
`define OFS_CNT_LO 16'h1024
`define OFS_CNT_HI 16'h1026
`define OFS_NEXT_EVENT 16'h1028
`define OFS_NEXT_WORD 16'h102A
`define OFS_CLR_WINDOW 16'h102E
`define OFS_CNT_RESET 16'h1040

// field positions
`define CHAIN_FIRST_BIT 1
`define CHAIN_LAST_BIT 0
`define ST_EMPTY_BIT 1
`define ST_FULL_BIT 2
`define ST_SEL_LSB 4
`define MODE_COUNT_ALL_BIT 14
`define MODE_PTR_AUTO_BIT 11

// reset values
`define RST_BYTE 8'h00
`define RST_THRESHOLD 5'h00
`define RST_WINDOW 10'h000
`define RST_CNT 24'h000000
`define RST_COUNT_ALL 1'b1
`define RST_PTR_AUTO 1'b1

// timing: fixed part of the fast clear window, and the 32 MHz step made from sys_clk
`define SYS_CLK_NS 4
`define FIXED_WINDOW_NS 7000
`define FIXED_WINDOW_CYC ((`FIXED_WINDOW_NS + `SYS_CLK_NS - 1) / `SYS_CLK_NS)
`define STEP_NUM 7'h10
`define STEP_DEN 7'h7D

`endif

// file: core/readout_ctrl_pkg.sv
package readout_ctrl_pkg;

    // one register access, held for one cycle
    typedef struct packed {
        logic wr;
        logic rd;
        logic [15:0] addr;
        logic [15:0] wdata;
    } reg_req_type;

    // mezzanine identification pins
    typedef struct packed {
        logic converter_select_hi;
        logic converter_select_lo;
        logic digitizer_select_hi;
        logic digitizer_select_lo;
    } board_sel_type;

    // write strobes of the mode bit set and clear registers
    typedef struct packed {
        logic set_wr;
        logic clr_wr;
        logic [15:0] data;
    } mode_write_type;

    typedef enum logic [1:0] {
        WIN_IDLE = 2'b00,
        WIN_FIXED = 2'b01,
        WIN_STEPS = 2'b11
    } window_state_type;

endpackage

// file: core/vme_readout_control_registers.sv
`timescale 1ns/1ps
`default_nettype none
`include "readout_ctrl_consts.svh"

// Notes on behaviour
// R1 - writable A31..A24 relocates module base
// R2 - writable A23..A16 relocates module base
// R3 - any one-shot write resets module, stores nothing
// R4 - master uses one-shot reset for debug only
// R5 - two write-only chain flags encode position
// R6 - interrupt when stored events equal threshold
// R7 - threshold resets zero; zero disables interrupt
// R8 - status shows output buffer empty
// R9 - status shows output buffer full
// R10 - status shows four mezzanine select bits
// R11 - 24-bit event counter in two registers
// R12 - count all or accepted triggers, bit 14
// R13 - counter clears on reset writes, data reset; here data reset clears it only when counting accepted triggers
// R14 - next-event write moves pointer to next event
// R15 - one-word write advances pointer one word
// R16 - auto advance off: only writes move pointer
// R17 - window is N 32 MHz periods plus 7 us
// R18 - master keeps window value at most 3F0
// R19 - counting mode defaults to every trigger
// R20 - pointer auto advance defaults to enabled
// R21 - each advance write gives exactly one step
module vme_readout_control_registers (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire readout_ctrl_pkg::reg_req_type reg_req,
    output logic [15:0] rd_data,
    output logic rd_ack,
    input wire readout_ctrl_pkg::mode_write_type mode_write,
    input wire logic soft_reset_in,
    input wire logic data_reset_in,
    input wire logic trigger_in,
    input wire logic trigger_accepted,
    input wire logic [5:0] stored_events,
    input wire logic buffer_empty,
    input wire logic buffer_full,
    input wire readout_ctrl_pkg::board_sel_type board_sel,
    input wire logic window_start,
    output logic [7:0] base_relocation_hi,
    output logic [7:0] base_relocation_lo,
    output logic module_reset,
    output logic chain_first,
    output logic chain_last,
    output logic irq_request,
    output logic count_every_trigger,
    output logic pointer_auto_advance,
    output logic ptr_next_event,
    output logic ptr_next_word,
    output logic clear_window_open
);

    logic [7:0] base_hi_q;
    logic [7:0] base_lo_q;
    logic one_shot_q;
    logic first_q;
    logic last_q;
    logic [4:0] threshold_q;
    logic irq_q;
    logic count_all_q;
    logic ptr_auto_q;
    logic [23:0] cnt_q;
    logic [23:0] cnt_d;
    logic next_event_q;
    logic next_word_q;
    logic [9:0] window_n_q;
    logic [15:0] rd_data_q;
    logic [15:0] rd_data_d;
    logic rd_ack_q;
    logic soft_rst;
    logic cnt_clear;
    logic cnt_inc;
    logic wr_hit_base_hi;
    logic wr_hit_base_lo;
    logic wr_hit_one_shot;
    logic wr_hit_chain;
    logic wr_hit_threshold;
    logic wr_hit_next_event;
    logic wr_hit_next_word;
    logic wr_hit_window;
    logic wr_hit_cnt_reset;
    readout_ctrl_pkg::window_state_type win_state_q;
    logic [10:0] fixed_cnt_q;
    logic [9:0] step_cnt_q;
    logic [6:0] phase_q;
    logic [7:0] phase_sum;
    logic step_tick;
    logic win_open_q;

    // write address decode
    assign wr_hit_base_hi = reg_req.wr && (reg_req.addr == `OFS_BASE_HI);
    assign wr_hit_base_lo = reg_req.wr && (reg_req.addr == `OFS_BASE_LO);
    assign wr_hit_one_shot = reg_req.wr && (reg_req.addr == `OFS_ONE_SHOT_RST);
    assign wr_hit_chain = reg_req.wr && (reg_req.addr == `OFS_CHAIN_CTRL);
    assign wr_hit_threshold = reg_req.wr && (reg_req.addr == `OFS_EVT_THRESHOLD);
    assign wr_hit_next_event = reg_req.wr && (reg_req.addr == `OFS_NEXT_EVENT);
    assign wr_hit_next_word = reg_req.wr && (reg_req.addr == `OFS_NEXT_WORD);
    assign wr_hit_window = reg_req.wr && (reg_req.addr == `OFS_CLR_WINDOW);
    assign wr_hit_cnt_reset = reg_req.wr && (reg_req.addr == `OFS_CNT_RESET);

    // module-wide reset from the one-shot location or from outside
    assign soft_rst = one_shot_q || soft_reset_in;

    // base relocation bytes, kept across soft resets
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            base_hi_q <= `RST_BYTE;
            base_lo_q <= `RST_BYTE;
        end else begin
            if (wr_hit_base_hi) begin
                base_hi_q <= reg_req.wdata[7:0]; // [R1]
            end
            if (wr_hit_base_lo) begin
                base_lo_q <= reg_req.wdata[7:0]; // [R2]
            end
        end
    end

    // one-shot reset: a pulse per write, data ignored
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            one_shot_q <= 1'b0;
        end else begin
            one_shot_q <= wr_hit_one_shot; // [R3]
        end
    end

    // chain position flags, upper bits ignored
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            first_q <= 1'b0;
            last_q <= 1'b0;
        end else if (soft_rst) begin
            first_q <= 1'b0;
            last_q <= 1'b0;
        end else if (wr_hit_chain) begin
            first_q <= reg_req.wdata[`CHAIN_FIRST_BIT]; // [R5]
            last_q <= reg_req.wdata[`CHAIN_LAST_BIT]; // [R5]
        end
    end

    // event threshold, cleared by system and soft resets
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            threshold_q <= `RST_THRESHOLD; // [R7]
        end else if (soft_rst) begin
            threshold_q <= `RST_THRESHOLD; // [R7]
        end else if (wr_hit_threshold) begin
            threshold_q <= reg_req.wdata[4:0];
        end
    end

    // interrupt request while stored events match a nonzero threshold
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= (threshold_q != `RST_THRESHOLD) &&
                     (stored_events == {1'b0, threshold_q}); // [R6] [R7]
        end
    end

    // counting and auto advance mode bits, set wins over clear
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            count_all_q <= `RST_COUNT_ALL; // [R19]
            ptr_auto_q <= `RST_PTR_AUTO; // [R20]
        end else if (soft_rst) begin
            count_all_q <= `RST_COUNT_ALL; // [R19]
            ptr_auto_q <= `RST_PTR_AUTO; // [R20]
        end else begin
            if (mode_write.set_wr && mode_write.data[`MODE_COUNT_ALL_BIT]) begin
                count_all_q <= 1'b1;
            end else if (mode_write.clr_wr && mode_write.data[`MODE_COUNT_ALL_BIT]) begin
                count_all_q <= 1'b0;
            end
            if (mode_write.set_wr && mode_write.data[`MODE_PTR_AUTO_BIT]) begin
                ptr_auto_q <= 1'b1;
            end else if (mode_write.clr_wr && mode_write.data[`MODE_PTR_AUTO_BIT]) begin
                ptr_auto_q <= 1'b0;
            end
        end
    end

    // event counter; a trigger in the clearing cycle still counts
    assign cnt_inc = count_all_q ? trigger_in : trigger_accepted; // [R12]
    assign cnt_clear = wr_hit_cnt_reset || soft_rst ||
                       (data_reset_in && !count_all_q); // [R13]
    always_comb begin
        cnt_d = cnt_q;
        if (cnt_clear) begin
            cnt_d = cnt_inc ? (`RST_CNT + 24'h000001) : `RST_CNT;
        end else if (cnt_inc) begin
            cnt_d = cnt_q + 24'h000001; // [R11]
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            cnt_q <= `RST_CNT; // [R13]
        end else begin
            cnt_q <= cnt_d;
        end
    end

    // pointer advance strobes, one per write, data ignored
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            next_event_q <= 1'b0;
            next_word_q <= 1'b0;
        end else begin
            next_event_q <= wr_hit_next_event; // [R14] [R16] [R21]
            next_word_q <= wr_hit_next_word; // [R15] [R16] [R21]
        end
    end

    // fast clear window value
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            window_n_q <= `RST_WINDOW;
        end else if (soft_rst) begin
            window_n_q <= `RST_WINDOW;
        end else if (wr_hit_window) begin
            window_n_q <= reg_req.wdata[9:0];
        end
    end

    // 32 MHz step by a fractional accumulator, restarted per window so N steps never last less than N periods
    assign phase_sum = {1'b0, phase_q} + {1'b0, `STEP_NUM};
    assign step_tick = (phase_sum >= {1'b0, `STEP_DEN});
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            phase_q <= 7'h00;
        end else if (win_state_q != readout_ctrl_pkg::WIN_STEPS) begin
            phase_q <= 7'h00;
        end else begin
            phase_q <= step_tick ? 7'(phase_sum - {1'b0, `STEP_DEN}) : phase_sum[6:0];
        end
    end

    // window timer: fixed 7 us, then N steps of the 32 MHz clock
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            win_state_q <= readout_ctrl_pkg::WIN_IDLE;
            fixed_cnt_q <= 11'h000;
            step_cnt_q <= 10'h000;
            win_open_q <= 1'b0;
        end else begin
            case (win_state_q)
                readout_ctrl_pkg::WIN_IDLE: begin
                    if (window_start) begin
                        win_state_q <= readout_ctrl_pkg::WIN_FIXED;
                        fixed_cnt_q <= 11'(`FIXED_WINDOW_CYC - 1); // [R17]
                        step_cnt_q <= window_n_q; // [R17]
                        win_open_q <= 1'b1;
                    end
                end
                readout_ctrl_pkg::WIN_FIXED: begin
                    if (soft_rst) begin
                        win_state_q <= readout_ctrl_pkg::WIN_IDLE;
                        win_open_q <= 1'b0;
                    end else if (fixed_cnt_q != 11'h000) begin
                        fixed_cnt_q <= fixed_cnt_q - 11'h001;
                    end else if (step_cnt_q == 10'h000) begin
                        win_state_q <= readout_ctrl_pkg::WIN_IDLE;
                        win_open_q <= 1'b0;
                    end else begin
                        win_state_q <= readout_ctrl_pkg::WIN_STEPS;
                    end
                end
                readout_ctrl_pkg::WIN_STEPS: begin
                    if (soft_rst) begin
                        win_state_q <= readout_ctrl_pkg::WIN_IDLE;
                        win_open_q <= 1'b0;
                    end else if (step_tick) begin
                        step_cnt_q <= step_cnt_q - 10'h001; // [R17]
                        if (step_cnt_q == 10'h001) begin
                            win_state_q <= readout_ctrl_pkg::WIN_IDLE;
                            win_open_q <= 1'b0;
                        end
                    end
                end
                default: begin
                    win_state_q <= readout_ctrl_pkg::WIN_IDLE;
                    win_open_q <= 1'b0;
                end
            endcase
        end
    end

    // read multiplexer; write-only and unmapped offsets read zero
    always_comb begin
        rd_data_d = 16'h0000;
        case (reg_req.addr)
            `OFS_BASE_HI: rd_data_d[7:0] = base_hi_q; // [R1]
            `OFS_BASE_LO: rd_data_d[7:0] = base_lo_q; // [R2]
            `OFS_EVT_THRESHOLD: rd_data_d[4:0] = threshold_q;
            `OFS_STATUS: begin
                rd_data_d[`ST_EMPTY_BIT] = buffer_empty; // [R8]
                rd_data_d[`ST_FULL_BIT] = buffer_full; // [R9]
                rd_data_d[`ST_SEL_LSB +: 4] = board_sel; // [R10]
            end
            `OFS_CNT_LO: rd_data_d = cnt_q[15:0]; // [R11]
            `OFS_CNT_HI: rd_data_d[7:0] = cnt_q[23:16]; // [R11]
            `OFS_CLR_WINDOW: rd_data_d[9:0] = window_n_q;
            default: rd_data_d = 16'h0000;
        endcase
    end

    // read answer one cycle after the request
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rd_data_q <= 16'h0000;
            rd_ack_q <= 1'b0;
        end else begin
            rd_ack_q <= reg_req.rd;
            if (reg_req.rd) begin
                rd_data_q <= rd_data_d;
            end
        end
    end

    // outputs straight from flops
    assign rd_data = rd_data_q;
    assign rd_ack = rd_ack_q;
    assign base_relocation_hi = base_hi_q;
    assign base_relocation_lo = base_lo_q;
    assign module_reset = one_shot_q;
    assign chain_first = first_q;
    assign chain_last = last_q;
    assign irq_request = irq_q;
    assign count_every_trigger = count_all_q;
    assign pointer_auto_advance = ptr_auto_q;
    assign ptr_next_event = next_event_q;
    assign ptr_next_word = next_word_q;
    assign clear_window_open = win_open_q;

    // checks
    a_base_hi_write: assert property (@(posedge sys_clk) disable iff (sys_rst) // [R1]
        wr_hit_base_hi |=> base_relocation_hi == $past(reg_req.wdata[7:0]))
        else $error("base high byte not taken");
    a_one_shot_pulse: assert property (@(posedge sys_clk) disable iff (sys_rst) // [R3]
        wr_hit_one_shot |=> module_reset ##1 (threshold_q == 5'h00 && cnt_q <= 24'h000001))
        else $error("one-shot write did not reset");
    a_chain_flags: assert property (@(posedge sys_clk) disable iff (sys_rst) // [R5]
        (wr_hit_chain && !soft_rst) |=> {chain_first, chain_last} == $past(reg_req.wdata[1:0]))
        else $error("chain flags wrong");
    a_irq_zero_off: assert property (@(posedge sys_clk) disable iff (sys_rst) // [R7]
        $past(threshold_q) == 5'h00 |-> !irq_request)
        else $error("interrupt with zero threshold");
    a_irq_match: assert property (@(posedge sys_clk) disable iff (sys_rst) // [R6]
        (threshold_q != 5'h00 && stored_events == {1'b0, threshold_q}) |=> irq_request)
        else $error("interrupt missed on match");
    a_count_mode: assert property (@(posedge sys_clk) disable iff (sys_rst) // [R12]
        (!cnt_clear && !count_all_q && !trigger_accepted) |=> cnt_q == $past(cnt_q))
        else $error("counter moved without accepted trigger");
    a_count_clear: assert property (@(posedge sys_clk) disable iff (sys_rst) // [R13]
        (wr_hit_cnt_reset && !cnt_inc) |=> cnt_q == 24'h000000)
        else $error("counter not cleared");
    a_one_step: assert property (@(posedge sys_clk) disable iff (sys_rst) // [R21]
        {ptr_next_event, ptr_next_word} == $past({wr_hit_next_event, wr_hit_next_word}))
        else $error("advance strobe does not match write");
    a_window_fixed: assert property (@(posedge sys_clk) disable iff (sys_rst) // [R17]
        (win_state_q == readout_ctrl_pkg::WIN_IDLE && window_start && !soft_rst)
        |=> clear_window_open [*8])
        else $error("fast clear window closed early");

endmodule
`default_nettype wire

// file: tb/vme_master_model.sv
`timescale 1ns/1ps
`default_nettype none
`include "readout_ctrl_consts.svh"

// bus master model: one register access at a time, inputs moved at the falling edge
module vme_master_model (
    input wire logic sys_clk,
    output var readout_ctrl_pkg::reg_req_type reg_req,
    input wire logic [15:0] rd_data,
    input wire logic rd_ack
);
    bit debug_ok = 1'b0;

    // bus idle at time zero
    initial begin
        reg_req = '0;
    end

    // write: strobe held one cycle, then lines released to flipped values
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        logic [15:0] dd;
        dd = d;
        if (a == `OFS_ONE_SHOT_RST && !debug_ok) begin
            return; // one-shot reset only when debugging
        end
        if (a == `OFS_CLR_WINDOW && d > 16'h03F0) begin
            dd = 16'h03F0; // window value kept in range
        end
        @(negedge sys_clk);
        reg_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: dd};
        @(negedge sys_clk);
        reg_req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~dd};
    endtask

    // read: answer taken in the cycle after the strobe
    task automatic rd(input logic [15:0] a, output logic [15:0] d, output logic k);
        @(negedge sys_clk);
        reg_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
        @(negedge sys_clk);
        d = rd_data;
        k = rd_ack;
        reg_req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 16'hFFFF};
    endtask
endmodule
`default_nettype wire

// file: tb/vme_readout_control_registers_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "readout_ctrl_consts.svh"

module vme_readout_control_registers_bench;
    logic sys_clk, sys_rst, soft_reset_in, data_reset_in, trigger_in, trigger_accepted;
    logic buffer_empty, buffer_full, window_start, rd_ack, module_reset, irq_request;
    logic chain_first, chain_last, count_every_trigger, pointer_auto_advance;
    logic ptr_next_event, ptr_next_word, clear_window_open;
    logic [5:0] stored_events;
    logic [7:0] base_relocation_hi, base_relocation_lo;
    logic [15:0] rd_data;
    readout_ctrl_pkg::reg_req_type reg_req;
    readout_ctrl_pkg::mode_write_type mode_write;
    readout_ctrl_pkg::board_sel_type board_sel;
    int bad_count = 0;
    int cmp_count = 0;

    vme_readout_control_registers dut (.sys_clk(sys_clk), .sys_rst(sys_rst),
        .reg_req(reg_req), .rd_data(rd_data), .rd_ack(rd_ack), .mode_write(mode_write),
        .soft_reset_in(soft_reset_in), .data_reset_in(data_reset_in),
        .trigger_in(trigger_in), .trigger_accepted(trigger_accepted),
        .stored_events(stored_events), .buffer_empty(buffer_empty),
        .buffer_full(buffer_full), .board_sel(board_sel), .window_start(window_start),
        .base_relocation_hi(base_relocation_hi), .base_relocation_lo(base_relocation_lo),
        .module_reset(module_reset), .chain_first(chain_first), .chain_last(chain_last),
        .irq_request(irq_request), .count_every_trigger(count_every_trigger),
        .pointer_auto_advance(pointer_auto_advance), .ptr_next_event(ptr_next_event),
        .ptr_next_word(ptr_next_word), .clear_window_open(clear_window_open));

    vme_master_model master (.sys_clk(sys_clk), .reg_req(reg_req), .rd_data(rd_data),
        .rd_ack(rd_ack));

    // 250 MHz clock
    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end

    task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %0t data %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk1(input logic got, input logic exp);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %0t flag %b expected %b", $time, got, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge sys_clk);
    endtask

    // read one register and compare value and answer strobe
    task automatic rdc(input logic [15:0] a, input logic [15:0] exp);
        logic [15:0] d;
        logic k;
        master.rd(a, d, k);
        chk1(k, 1'b1);
        chk16(d, exp);
    endtask

    task automatic mode(input logic s, input logic c, input logic [15:0] d);
        mode_write = '{set_wr: s, clr_wr: c, data: d};
        cyc(1);
        mode_write = '0;
        cyc(1);
    endtask

    task automatic trig(input logic all, input logic acc);
        trigger_in = all;
        trigger_accepted = acc;
        cyc(1);
        trigger_in = 1'b0;
        trigger_accepted = 1'b0;
        cyc(1);
    endtask

    task automatic t_defaults;
        chk1(count_every_trigger, 1'b1);
        chk1(pointer_auto_advance, 1'b1);
        rdc(`OFS_EVT_THRESHOLD, 16'h0000);
        rdc(16'h1030, 16'h0000);
    endtask

    task automatic t_base;
        master.wr(`OFS_BASE_HI, 16'h12AB);
        chk16({8'h00, base_relocation_hi}, 16'h00AB);
        rdc(`OFS_BASE_HI, 16'h00AB);
        master.wr(`OFS_BASE_LO, 16'h3456);
        chk16({8'h00, base_relocation_lo}, 16'h0056);
        rdc(`OFS_BASE_LO, 16'h0056);
    endtask

    // all four chain codes, upper bits set and ignored
    task automatic t_chain;
        for (int i = 0; i < 4; i++) begin
            master.wr(`OFS_CHAIN_CTRL, 16'hFFFC | 16'(i));
            chk1(chain_first, i[1]);
            chk1(chain_last, i[0]);
        end
        rdc(`OFS_CHAIN_CTRL, 16'h0000);
    endtask

    task automatic t_irq;
        master.wr(`OFS_EVT_THRESHOLD, 16'hFFFF);
        rdc(`OFS_EVT_THRESHOLD, 16'h001F);
        stored_events = 6'd31;
        cyc(3);
        chk1(irq_request, 1'b1);
        stored_events = 6'd30;
        cyc(3);
        chk1(irq_request, 1'b0);
        master.wr(`OFS_EVT_THRESHOLD, 16'h0000);
        stored_events = 6'd0;
        cyc(3);
        chk1(irq_request, 1'b0);
    endtask

    task automatic t_status;
        for (int i = 0; i < 4; i++) begin
            buffer_empty = i[0];
            buffer_full = i[1];
            board_sel = 4'(i * 5 + 2);
            rdc(`OFS_STATUS, {8'h00, 4'(i * 5 + 2), 1'b0, i[1], i[0], 1'b0});
        end
    endtask

    task automatic t_counter;
        master.wr(`OFS_CNT_RESET, 16'h0000);
        repeat (3) trig(1'b1, 1'b0);
        rdc(`OFS_CNT_LO, 16'h0003);
        rdc(`OFS_CNT_HI, 16'h0000);
        mode(1'b0, 1'b1, 16'h4000);
        chk1(count_every_trigger, 1'b0);
        trig(1'b1, 1'b0);
        trig(1'b1, 1'b1);
        rdc(`OFS_CNT_LO, 16'h0004);
        data_reset_in = 1'b1;
        cyc(1);
        data_reset_in = 1'b0;
        rdc(`OFS_CNT_LO, 16'h0000);
        trig(1'b0, 1'b1);
        master.wr(`OFS_CNT_RESET, 16'hFFFF);
        rdc(`OFS_CNT_LO, 16'h0000);
        mode(1'b1, 1'b0, 16'h4000);
        trig(1'b1, 1'b0);
        data_reset_in = 1'b1;
        cyc(1);
        data_reset_in = 1'b0;
        rdc(`OFS_CNT_LO, 16'h0001);
        soft_reset_in = 1'b1;
        cyc(1);
        soft_reset_in = 1'b0;
        rdc(`OFS_CNT_LO, 16'h0000);
        trig(1'b1, 1'b0);
        sys_rst = 1'b1;
        cyc(2);
        sys_rst = 1'b0;
        rdc(`OFS_CNT_LO, 16'h0000);
    endtask

    task automatic t_pointer;
        master.wr(`OFS_NEXT_EVENT, 16'h0000);
        chk1(ptr_next_event, 1'b1);
        chk1(ptr_next_word, 1'b0);
        cyc(1);
        chk1(ptr_next_event, 1'b0);
        master.wr(`OFS_NEXT_WORD, 16'hFFFF);
        chk1(ptr_next_word, 1'b1);
        chk1(ptr_next_event, 1'b0);
        cyc(1);
        chk1(ptr_next_word, 1'b0);
        mode(1'b0, 1'b1, 16'h0800);
        chk1(pointer_auto_advance, 1'b0);
        rdc(`OFS_CNT_LO, 16'h0000);
        chk1(ptr_next_word | ptr_next_event, 1'b0);
        mode(1'b1, 1'b0, 16'h0800);
    endtask

    // window length with a second start pulse ignored while open
    task automatic t_window(input logic [15:0] n);
        int cnt;
        int lo;
        cnt = 0;
        lo = 1750 + (int'(n) * 125) / 16 - 1;
        master.wr(`OFS_CLR_WINDOW, n);
        rdc(`OFS_CLR_WINDOW, n);
        window_start = 1'b1;
        cyc(1);
        while (clear_window_open === 1'b1 && cnt < 12000) begin
            window_start = (cnt == 100);
            cnt++;
            cyc(1);
        end
        window_start = 1'b0;
        chk1(cnt >= lo && cnt <= lo + 2, 1'b1);
    endtask

    task automatic t_oneshot;
        master.wr(`OFS_EVT_THRESHOLD, 16'h0007);
        master.wr(`OFS_CHAIN_CTRL, 16'h0003);
        mode(1'b0, 1'b1, 16'h4800);
        trig(1'b1, 1'b1);
        master.debug_ok = 1'b1;
        master.wr(`OFS_ONE_SHOT_RST, 16'h0000);
        chk1(module_reset, 1'b1);
        cyc(1);
        chk1(module_reset, 1'b0);
        chk1(chain_first | chain_last, 1'b0);
        chk1(count_every_trigger, 1'b1);
        chk1(pointer_auto_advance, 1'b1);
        rdc(`OFS_EVT_THRESHOLD, 16'h0000);
        rdc(`OFS_CNT_LO, 16'h0000);
        rdc(`OFS_ONE_SHOT_RST, 16'h0000);
    endtask

    task automatic results;
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // watchdog well beyond the expected run of some 13300 cycles
    initial begin
        #160000;
        bad_count++;
        $display("[FAIL] %0t watchdog expired", $time);
        results();
    end

    // main sequence
    initial begin
        sys_rst = 1'b1;
        mode_write = '0;
        soft_reset_in = 1'b0;
        data_reset_in = 1'b0;
        trigger_in = 1'b0;
        trigger_accepted = 1'b0;
        stored_events = 6'd0;
        buffer_empty = 1'b1;
        buffer_full = 1'b0;
        board_sel = '0;
        window_start = 1'b0;
        repeat (8) @(negedge sys_clk);
        sys_rst = 1'b0;
        t_defaults();
        t_base();
        t_chain();
        t_irq();
        t_status();
        t_counter();
        t_pointer();
        t_window(16'h0000);
        t_window(16'h0005);
        t_window(16'h03F0);
        t_oneshot();
        results();
    end
endmodule
`default_nettype wire
